// File: verilog/aspt_pkg.sv
// constants, state type and timing counts for the async sram host port
// Contract
// - read needs strobe high, output enable low, chip selected, a lane on.
// - write happens only in the overlap of strobe, selects and a byte enable.
// - write recovery from first releasing edge to cycle end is at least 0 ns.
// - never drive data against memory output at the start of a write.
// - read and write cycles last at least 70 ns; address setup 0 ns.
// - address, select and byte enables valid 60 ns before write end.
// - strobe pulse 50 ns; data set up 30 ns, held 0 ns after write end.
// - deselect before retention, then wait one read cycle before access.
package aspt_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_PERIOD_NS = 100;

   localparam int T_RC_NS = 70;
   localparam int T_WC_NS = 70;
   localparam int T_AW_NS = 60;
   localparam int T_CW_NS = 60;
   localparam int T_WP_NS = 50;
   localparam int T_DW_NS = 30;
   localparam int T_AS_NS = 0;
   localparam int T_WR_NS = 0;
   localparam int T_DH_NS = 0;
   localparam int T_CDR_NS = 0;
   localparam int T_R_NS = T_RC_NS;

   typedef logic [3:0] aspt_cnt_t;

   // least time in whole clocks, never below one
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // counts are loaded as n-1 so a state lasts n clocks
   localparam aspt_cnt_t SETUP_CNT = aspt_cnt_t'(cyc_min(T_AS_NS) - 1);
   localparam aspt_cnt_t PULSE_CNT = aspt_cnt_t'(imax(imax(
      cyc_min(T_WP_NS), cyc_min(T_DW_NS)),
      imax(cyc_min(T_AW_NS), cyc_min(T_CW_NS))) - 1);
   localparam aspt_cnt_t END_CNT = aspt_cnt_t'(imax(imax(
      cyc_min(T_WR_NS), cyc_min(T_DH_NS)),
      cyc_min(T_WC_NS) - 2) - 1);
   localparam aspt_cnt_t READ_CNT = aspt_cnt_t'(cyc_min(T_RC_NS)
      + SYNC_STAGES - 1);
   localparam aspt_cnt_t CDR_CNT = aspt_cnt_t'(cyc_min(T_CDR_NS) - 1);
   localparam aspt_cnt_t RECOVER_CNT = aspt_cnt_t'(cyc_min(T_R_NS) - 1);

   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam aspt_cnt_t CNT_ZERO = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_READ     = 3'b001,
      ST_WSETUP   = 3'b011,
      ST_WPULSE   = 3'b010,
      ST_WEND     = 3'b110,
      ST_RET_WAIT = 3'b100,
      ST_RET_HOLD = 3'b101,
      ST_RECOVER  = 3'b111
   } aspt_state_t;
endpackage

// File: verilog/aspt_sync_if.sv
// read data carried from the pin synchroniser to the host controller
`timescale 1ns/1ps
interface aspt_sync_if;
   logic [aspt_pkg::DATA_W-1:0] q;
   logic stable;
   modport src (output q, output stable);
   modport dst (input q, input stable);
endinterface

// File: verilog/aspt_data_sync.sv
// three-stage synchroniser for the memory data pins
`timescale 1ns/1ps
module aspt_data_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pin side
   input wire logic [aspt_pkg::DATA_W-1:0] d_i,
   // controller side
   aspt_sync_if.src sync
);
   import aspt_pkg::*;

   logic [DATA_W-1:0] stage [SYNC_STAGES];

   // first stage is read only by the second
   genvar g;
   generate
      for (g = 0; g < SYNC_STAGES; g++) begin : g_stage
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               stage[g] <= DATA_RST;
            end else begin
               stage[g] <= (g == 0) ? d_i : stage[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   assign sync.q = stage[SYNC_STAGES-1];
   assign sync.stable = (stage[SYNC_STAGES-2] == stage[SYNC_STAGES-1]);
endmodule

// File: verilog/aspt_host.sv
// host controller that runs an asynchronous 128k x 16 sram through its pins
`timescale 1ns/1ps
module aspt_host (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // user request
   input wire logic REQ_I,
   input wire logic WRITE_I,
   input wire logic [aspt_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [aspt_pkg::DATA_W-1:0] WDATA_I,
   input wire logic [1:0] BYTE_EN_I,
   input wire logic RETAIN_REQ_I,
   // user answer
   output logic READY_O,
   output logic [aspt_pkg::DATA_W-1:0] RDATA_O,
   output logic RDATA_VALID_O,
   output logic WRITE_DONE_O,
   output logic RETAIN_SAFE_O,
   // memory pins
   output logic [aspt_pkg::ADDR_W-1:0] SRAM_ADDR_O,
   output logic SELECT_LOW_ACTIVE_N_O,
   output logic SELECT_HIGH_ACTIVE_O,
   output logic WRITE_STROBE_N_O,
   output logic OUTPUT_ENABLE_N_O,
   output logic LOW_BYTE_ENABLE_N_O,
   output logic UPPER_BYTE_ENABLE_N_O,
   input wire logic [aspt_pkg::DATA_W-1:0] SRAM_DATA_I,
   output logic [aspt_pkg::DATA_W-1:0] SRAM_DATA_O,
   output logic SRAM_DATA_OE_O
);
   import aspt_pkg::*;

   aspt_state_t state;
   aspt_state_t next_state;
   aspt_cnt_t cnt;
   aspt_cnt_t next_cnt;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [1:0] lanes;
   logic [DATA_W-1:0] rdata;
   logic rdata_valid;
   logic write_done;

   aspt_sync_if rd_sync ();

   aspt_data_sync u_sync (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .d_i(SRAM_DATA_I),
      .sync(rd_sync)
   );

   // decoding of the next state into pin levels
   function automatic logic is_access(input aspt_state_t s);
      return (s == ST_READ) || (s == ST_WSETUP) || (s == ST_WPULSE)
         || (s == ST_WEND);
   endfunction

   function automatic logic is_write(input aspt_state_t s);
      return (s == ST_WSETUP) || (s == ST_WPULSE) || (s == ST_WEND);
   endfunction

   wire cnt_done = (cnt == CNT_ZERO);
   wire idle = (state == ST_IDLE);
   // a request with no byte lane selected would not touch the part
   wire lanes_any = |BYTE_EN_I;
   wire accept = idle && !RETAIN_REQ_I && REQ_I && lanes_any;
   wire rd_take = (state == ST_READ) && cnt_done && rd_sync.stable;
   wire [1:0] next_lanes = accept ? BYTE_EN_I : lanes;
   wire next_sel = is_access(next_state);
   wire next_oe_n = !(next_state == ST_READ);
   wire next_we_n = !(next_state == ST_WPULSE);
   // output enable stays high through a write, so the part never drives
   // while we do and its outputs stay floating under the strobe
   wire next_data_oe = is_write(next_state);

   assign READY_O = idle && !RETAIN_REQ_I;
   assign RDATA_O = rdata;
   assign RDATA_VALID_O = rdata_valid;
   assign WRITE_DONE_O = write_done;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         ST_IDLE: begin
            if (RETAIN_REQ_I) begin
               next_state = ST_RET_WAIT;
               next_cnt = CDR_CNT;
            end else if (accept && WRITE_I) begin
               next_state = ST_WSETUP;
               next_cnt = SETUP_CNT;
            end else if (accept) begin
               next_state = ST_READ;
               next_cnt = READ_CNT;
            end
         end
         ST_READ: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else if (rd_sync.stable) begin
               next_state = ST_IDLE;
            end
         end
         ST_WSETUP: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_state = ST_WPULSE;
               next_cnt = PULSE_CNT;
            end
         end
         ST_WPULSE: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_state = ST_WEND;
               next_cnt = END_CNT;
            end
         end
         ST_WEND: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_RET_WAIT: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_state = ST_RET_HOLD;
            end
         end
         ST_RET_HOLD: begin
            if (!RETAIN_REQ_I) begin
               next_state = ST_RECOVER;
               next_cnt = RECOVER_CNT;
            end
         end
         ST_RECOVER: begin
            if (!cnt_done) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_IDLE;
         cnt <= CNT_ZERO;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // address and data only load in idle, so they never move under the
   // strobe or inside the hold after it
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         addr <= ADDR_RST;
         wdata <= DATA_RST;
         lanes <= 2'h0;
      end else if (accept) begin
         addr <= ADDR_I;
         wdata <= WDATA_I;
         lanes <= BYTE_EN_I;
      end
   end

   // pins are registered so that no decode glitch reaches the part
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SELECT_LOW_ACTIVE_N_O <= 1'b1;
         SELECT_HIGH_ACTIVE_O <= 1'b0;
         WRITE_STROBE_N_O <= 1'b1;
         OUTPUT_ENABLE_N_O <= 1'b1;
         LOW_BYTE_ENABLE_N_O <= 1'b1;
         UPPER_BYTE_ENABLE_N_O <= 1'b1;
         SRAM_DATA_OE_O <= 1'b0;
      end else begin
         SELECT_LOW_ACTIVE_N_O <= !next_sel;
         SELECT_HIGH_ACTIVE_O <= next_sel;
         WRITE_STROBE_N_O <= next_we_n;
         OUTPUT_ENABLE_N_O <= next_oe_n;
         LOW_BYTE_ENABLE_N_O <= !(next_sel && next_lanes[0]);
         UPPER_BYTE_ENABLE_N_O <= !(next_sel && next_lanes[1]);
         SRAM_DATA_OE_O <= next_data_oe;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SRAM_ADDR_O <= ADDR_RST;
         SRAM_DATA_O <= DATA_RST;
      end else begin
         SRAM_ADDR_O <= accept ? ADDR_I : addr;
         SRAM_DATA_O <= accept ? WDATA_I : wdata;
      end
   end

   // read data sampled only once two stages agree
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata <= DATA_RST;
         rdata_valid <= 1'b0;
         write_done <= 1'b0;
         RETAIN_SAFE_O <= 1'b0;
      end else begin
         if (rd_take) begin
            rdata[LANE_W-1:0] <= lanes[0] ? rd_sync.q[LANE_W-1:0]
               : 8'h00;
            rdata[DATA_W-1:LANE_W] <= lanes[1]
               ? rd_sync.q[DATA_W-1:LANE_W] : 8'h00;
         end
         rdata_valid <= rd_take;
         write_done <= (state == ST_WEND) && cnt_done;
         RETAIN_SAFE_O <= (next_state == ST_RET_HOLD);
      end
   end
endmodule

// File: verif/aspt_sram_model.sv
// behavioural async sram standing on the far side of the host port
`timescale 1ns/1ps
module aspt_sram_model (
   // host pins
   input wire logic [16:0] addr_i,
   input wire logic sel_n_i,
   input wire logic sel_h_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic lb_n_i,
   input wire logic ub_n_i,
   input wire logic [15:0] dq_i,
   // read drive
   output logic [15:0] q_o,
   output logic [1:0] drv_o
);
   logic [15:0] mem [0:255];
   wire act = !sel_n_i && sel_h_i;
   wire [1:0] lane = {!ub_n_i, !lb_n_i} & {2{act}};
   wire wr = |lane && !we_n_i;
   // a low strobe floats the lanes whatever the other enables say
   wire [1:0] lane_out = (we_n_i && !oe_n_i) ? lane : 2'h0;
   // lanes open 5 ns late and float again well inside 25 ns
   assign #5 drv_o = lane_out;
   // old data stays 10 ns after an address move, inside the access limit
   assign #10 q_o = mem[addr_i[7:0]];
   // data is taken when the overlap closes; lanes dropped first lose it
   always @(negedge wr) begin
      if (lane[0]) mem[addr_i[7:0]][7:0] = dq_i[7:0];
      if (lane[1]) mem[addr_i[7:0]][15:8] = dq_i[15:8];
   end
endmodule

// File: verif/aspt_host_props.sv
// concurrent checks on the pins and user ports of the async sram host port
`timescale 1ns/1ps
module aspt_host_props (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // user side
   input wire logic REQ_I,
   input wire logic WRITE_I,
   input wire logic [1:0] BYTE_EN_I,
   input wire logic READY_O,
   input wire logic WRITE_DONE_O,
   input wire logic RETAIN_SAFE_O,
   // memory pins
   input wire logic [aspt_pkg::ADDR_W-1:0] SRAM_ADDR_O,
   input wire logic SELECT_LOW_ACTIVE_N_O,
   input wire logic SELECT_HIGH_ACTIVE_O,
   input wire logic WRITE_STROBE_N_O,
   input wire logic OUTPUT_ENABLE_N_O,
   input wire logic SRAM_DATA_OE_O
);
   import aspt_pkg::*;
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   wire sel = !SELECT_LOW_ACTIVE_N_O && SELECT_HIGH_ACTIVE_O;
   wire we = WRITE_STROBE_N_O;
   wire doe = SRAM_DATA_OE_O;
   wire take = REQ_I && READY_O && |BYTE_EN_I;
   property p_ovl; !we |-> sel && doe; endproperty
   a_ovl: assert property (p_ovl)
      else $error("strobe outside select overlap");
   property p_fight; doe |-> OUTPUT_ENABLE_N_O; endproperty
   a_fight: assert property (p_fight)
      else $error("host drives while memory may drive");
   property p_pulse; $fell(we) |=> $rose(we); endproperty
   a_pulse: assert property (p_pulse)
      else $error("strobe pulse length");
   property p_setup; $fell(we) |-> $past(sel) && $stable(SRAM_ADDR_O);
   endproperty
   a_setup: assert property (p_setup)
      else $error("no setup before strobe");
   property p_hold; $rose(we) |-> sel && doe && $stable(SRAM_ADDR_O);
   endproperty
   a_hold: assert property (p_hold)
      else $error("no hold after strobe");
   property p_wtake; take && WRITE_I |=> sel && we ##1 !we
      ##[1:3] WRITE_DONE_O; endproperty
   a_wtake: assert property (p_wtake)
      else $error("write sequence");
   property p_rtake; take && !WRITE_I |=>
      (sel && we && !OUTPUT_ENABLE_N_O)[*3]; endproperty
   a_rtake: assert property (p_rtake)
      else $error("read cycle too short");
   property p_ret; RETAIN_SAFE_O |-> !sel && ($past(SELECT_LOW_ACTIVE_N_O)
      || !$past(SELECT_HIGH_ACTIVE_O)); endproperty
   a_ret: assert property (p_ret)
      else $error("retention while selected");
   property p_refuse; REQ_I && READY_O && BYTE_EN_I == 2'h0 |=> !sel;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("request without lanes taken");
endmodule
bind aspt_host aspt_host_props aspt_host_props_i (.*);

// File: verif/test_aspt_host.sv
// self-checking bench for the async sram host port
`timescale 1ns/1ps
module test_aspt_host;
   import aspt_pkg::*;
   logic MCLK_I, RST_N_I, REQ_I, WRITE_I, RETAIN_REQ_I, READY_O;
   logic RDATA_VALID_O, WRITE_DONE_O, RETAIN_SAFE_O, SRAM_DATA_OE_O;
   logic SELECT_LOW_ACTIVE_N_O, SELECT_HIGH_ACTIVE_O, WRITE_STROBE_N_O;
   logic OUTPUT_ENABLE_N_O, LOW_BYTE_ENABLE_N_O, UPPER_BYTE_ENABLE_N_O;
   logic [ADDR_W-1:0] ADDR_I, SRAM_ADDR_O;
   logic [DATA_W-1:0] WDATA_I, RDATA_O, SRAM_DATA_O, mq, last;
   logic [1:0] BYTE_EN_I, drv;
   wire [DATA_W-1:0] SRAM_DATA_I;
   int errors, n_tests, cyc;
   // an undriven lane shows the inverse of its last driven value, so stale
   // data never passes for a read, yet it stays steady like a held bus
   wire [15:0] mdrv = {{8{drv[1]}}, {8{drv[0]}}};
   wire [15:0] hdrv = SRAM_DATA_OE_O ? 16'hFFFF : mdrv;
   assign SRAM_DATA_I = SRAM_DATA_OE_O ? SRAM_DATA_O
      : (mq & mdrv) | (~last & ~mdrv);
   aspt_host aspt_host_i (.*);
   aspt_sram_model aspt_sram_model_i (.addr_i(SRAM_ADDR_O),
      .sel_n_i(SELECT_LOW_ACTIVE_N_O), .sel_h_i(SELECT_HIGH_ACTIVE_O),
      .we_n_i(WRITE_STROBE_N_O), .oe_n_i(OUTPUT_ENABLE_N_O),
      .lb_n_i(LOW_BYTE_ENABLE_N_O), .ub_n_i(UPPER_BYTE_ENABLE_N_O),
      .dq_i(SRAM_DATA_I), .q_o(mq), .drv_o(drv));
   initial begin
      MCLK_I = 1'h0;
      forever #50 MCLK_I = ~MCLK_I;
   end
   task automatic conclude();
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge MCLK_I) begin
      last <= (SRAM_DATA_I & hdrv) | (last & ~hdrv);
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one access; a request with no lane must get no answer at all
   task automatic go(input logic w, input logic [16:0] a,
      input logic [15:0] d, input logic [1:0] b, input logic [15:0] e);
      while (!READY_O) @(negedge MCLK_I);
      @(posedge MCLK_I);
      {REQ_I, WRITE_I, ADDR_I, WDATA_I, BYTE_EN_I} <= {1'h1, w, a, d, b};
      @(posedge MCLK_I);
      REQ_I <= 1'h0;
      repeat (12) begin
         @(negedge MCLK_I);
         if (RDATA_VALID_O || WRITE_DONE_O) break;
      end
      chk("answer", {15'h0, |b},
         {15'h0, RDATA_VALID_O | WRITE_DONE_O});
      if (!w && |b) chk("rdata", e, RDATA_O);
   endtask
   task automatic t_lanes();
      go(1'h1, 17'h00010, 16'hA5C3, 2'h3, 16'h0);
      go(1'h1, 17'h00010, 16'h1234, 2'h1, 16'h0);
      go(1'h1, 17'h00010, 16'h5678, 2'h2, 16'h0);
      go(1'h1, 17'h1FFFF, 16'hFFFF, 2'h3, 16'h0);
      go(1'h0, 17'h00010, 16'h0, 2'h3, 16'h5634);
      go(1'h0, 17'h00010, 16'h0, 2'h1, 16'h0034);
      go(1'h0, 17'h00010, 16'h0, 2'h2, 16'h5600);
      go(1'h0, 17'h1FFFF, 16'h0, 2'h3, 16'hFFFF);
   endtask
   task automatic t_refuse();
      go(1'h1, 17'h00010, 16'h0000, 2'h0, 16'h0);
      go(1'h0, 17'h00010, 16'h0, 2'h3, 16'h5634);
   endtask
   task automatic t_retain();
      @(posedge MCLK_I);
      RETAIN_REQ_I <= 1'h1;
      repeat (3) @(negedge MCLK_I);
      chk("safe", 16'h1, {15'h0, RETAIN_SAFE_O});
      chk("deselect", 16'h1,
         {15'h0, SELECT_LOW_ACTIVE_N_O | ~SELECT_HIGH_ACTIVE_O});
      @(posedge MCLK_I);
      RETAIN_REQ_I <= 1'h0;
      go(1'h0, 17'h1FFFF, 16'h0, 2'h3, 16'hFFFF);
   endtask
   initial begin
      {RST_N_I, REQ_I, WRITE_I, RETAIN_REQ_I, ADDR_I, WDATA_I} = 37'h0;
      BYTE_EN_I = 2'h0;
      last = 16'h0;
      errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (3) @(posedge MCLK_I);
      RST_N_I <= 1'h1;
      t_lanes();
      t_refuse();
      t_retain();
      conclude();
   end
endmodule
